//--- pkg/vic_pkg.sv
package vic_pkg;
  localparam int VIC_LINES        = 6;
  localparam int VIC_EXT_LINES    = 4;
  localparam int VIC_MASTER_BIT   = 7;
  localparam logic [7:0] VIC_MASK_RESET = 8'h00;
  localparam logic [7:0] VIC_PRIO_RESET = 8'h00;
  localparam logic [5:0] VIC_PEND_RESET = 6'h00;
  localparam logic [3:0] VIC_PIN_RESET  = 4'hf;
  // vector pair base for line n is 2*n
  localparam logic [7:0] VIC_VEC_STEP   = 8'h02;

  typedef struct packed {
    logic       valid;
    logic [2:0] line;
    logic [7:0] vec_lo;
    logic [7:0] vec_hi;
  } vic_grant_s;
endpackage : vic_pkg

//--- src/vic_ctrl.sv
`timescale 1ns/10ps
// Overview of operation
// - six request lines fed by eight sources: four pins, serial rx/tx, two timers
// - per-line mask bits; mask bit 7 is master enable blocking all lines
// - priority register steers encoder choosing which pending enabled request wins
// - line n vector stored at program bytes 2n and 2n+1, 16-bit address
// - lines 0..3 come from port pins bit 2, 3, 1, 0 respectively
// - external lines request on falling edge only
// - line 4 timer zero or serial tx; line 3 also rx; line 5 timer one
// - grant runs interrupt cycle: clear global enable, save state, jump to vector
// - enable instruction sets global enable again, allowing nesting
// - return instruction restores state and sets global enable again
// - pending register readable at any time for polling
module vic_ctrl (
  input  wire logic              CLK_I,
  input  wire logic              RESET_I,
  input  wire logic              CE_I,
  input  wire logic [3:0]        PIN_I,
  input  wire logic              SERIAL_RX_I,
  input  wire logic              SERIAL_TX_I,
  input  wire logic              TIMER0_I,
  input  wire logic              TIMER1_I,
  input  wire logic              MASK_WR_I,
  input  wire logic              PRIO_WR_I,
  input  wire logic [7:0]        WDATA_I,
  input  wire logic              ENABLE_INSN_I,
  input  wire logic              DISABLE_INSN_I,
  input  wire logic              RETURN_INSN_I,
  input  wire logic              CYCLE_ACK_I,
  output logic                   IRQ_REQ_O,
  output vic_pkg::vic_grant_s    GRANT_O,
  output logic [7:0]             MASK_O,
  output logic [7:0]             PRIO_O,
  output logic [5:0]             PENDING_O
);
  import vic_pkg::*;

  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [3:0] pin_last;
  logic [5:0] event_in;
  logic [5:0] active;
  logic [2:0] winner;
  logic       any_active;
  logic [5:0] next_pending;
  logic [7:0] interrupt_mask_reg;
  logic [7:0] interrupt_priority_reg;
  logic [5:0] pending;

  // two-stage sync on pins; only the second stage feeds edge logic
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      pin_meta <= VIC_PIN_RESET;
      pin_sync <= VIC_PIN_RESET;
      pin_last <= VIC_PIN_RESET;
    end else if (CE_I) begin
      pin_meta <= PIN_I;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  // pin bits 2,3,1,0 map to lines 0..3; falling edge only
  logic [3:0] fall;
  assign fall = pin_last & ~pin_sync;
  assign event_in[0] = fall[2];
  assign event_in[1] = fall[3];
  assign event_in[2] = fall[1];
  assign event_in[3] = fall[0] | SERIAL_RX_I;
  // timer zero and tx are exclusive users of line four
  assign event_in[4] = TIMER0_I | SERIAL_TX_I;
  assign event_in[5] = TIMER1_I;

  // mask register and priority: software must disable first
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      interrupt_mask_reg <= VIC_MASK_RESET;
    end else if (CE_I) begin
      if (MASK_WR_I) begin
        interrupt_mask_reg <= WDATA_I;
      end else if (CYCLE_ACK_I || DISABLE_INSN_I) begin
        interrupt_mask_reg[VIC_MASTER_BIT] <= 1'b0;
      end else if (ENABLE_INSN_I || RETURN_INSN_I) begin
        interrupt_mask_reg[VIC_MASTER_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      interrupt_priority_reg <= VIC_PRIO_RESET;
    end else if (CE_I && PRIO_WR_I) begin
      interrupt_priority_reg <= WDATA_I;
    end
  end

  assign active = pending & interrupt_mask_reg[5:0] & {6{interrupt_mask_reg[VIC_MASTER_BIT]}};

  // rotating priority: search starts at line given by priority low bits, or at line 0 when they exceed 5
  always_comb begin
    logic [2:0] start;
    logic [2:0] idx;
    start = (interrupt_priority_reg[2:0] > 3'h5) ? 3'h0 : interrupt_priority_reg[2:0];
    winner = 3'h0;
    any_active = 1'b0;
    idx = 3'h0;
    for (int k = VIC_LINES - 1; k >= 0; k--) begin
      idx = 3'((int'(start) + k) % VIC_LINES);
      if (active[idx]) begin
        winner = idx;
        any_active = 1'b1;
      end
    end
  end

  // set beats clear on the grant cycle
  always_comb begin
    next_pending = pending;
    if (CYCLE_ACK_I && GRANT_O.valid) begin
      next_pending[GRANT_O.line] = 1'b0;
    end
    next_pending = next_pending | event_in;
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      pending <= VIC_PEND_RESET;
    end else if (CE_I) begin
      pending <= next_pending;
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      GRANT_O <= '0;
    end else if (CE_I) begin
      GRANT_O.valid  <= any_active && !CYCLE_ACK_I;
      GRANT_O.line   <= winner;
      GRANT_O.vec_lo <= 8'({5'h00, winner} * VIC_VEC_STEP);
      GRANT_O.vec_hi <= 8'({5'h00, winner} * VIC_VEC_STEP + 8'h01);
    end
  end

  assign IRQ_REQ_O = GRANT_O.valid;
  assign MASK_O    = interrupt_mask_reg;
  assign PRIO_O    = interrupt_priority_reg;
  assign PENDING_O = pending;

  a_ack_clears_master: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && CYCLE_ACK_I && !MASK_WR_I) |=> !interrupt_mask_reg[VIC_MASTER_BIT])
    else $error("master enable not cleared by interrupt cycle");
  a_enable_sets_master: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && ENABLE_INSN_I && !MASK_WR_I && !CYCLE_ACK_I && !DISABLE_INSN_I) |=> interrupt_mask_reg[VIC_MASTER_BIT])
    else $error("enable instruction did not set master enable");
  a_return_sets_master: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && RETURN_INSN_I && !MASK_WR_I && !CYCLE_ACK_I && !DISABLE_INSN_I) |=> interrupt_mask_reg[VIC_MASTER_BIT])
    else $error("return did not set master enable");
  a_master_blocks_all: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && !interrupt_mask_reg[VIC_MASTER_BIT]) |=> !IRQ_REQ_O)
    else $error("request raised while master disabled");
  a_fall_sets_line0: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && pin_last[2] && !pin_sync[2]) |=> pending[0])
    else $error("falling edge on pin bit 2 missed");
  a_rise_no_line1: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && !pending[1] && !(pin_last[3] && !pin_sync[3])) |=> !pending[1])
    else $error("line one set without falling edge");
  a_timer1_line5: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && TIMER1_I) |=> pending[5])
    else $error("timer one event lost");
  a_vector_pair: assert property (@(posedge CLK_I) disable iff (RESET_I)
    GRANT_O.valid |-> (GRANT_O.vec_lo == {4'h0, GRANT_O.line, 1'b0} && GRANT_O.vec_hi == {4'h0, GRANT_O.line, 1'b1}))
    else $error("vector location wrong");
  a_grant_masked: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && any_active) |-> active[winner])
    else $error("winner not an active request");
  a_pending_mask_free: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && SERIAL_TX_I && interrupt_mask_reg[4] == 1'b0) |=> pending[4])
    else $error("masked event not recorded");

  // checks look one edge ahead; each but the freeze check needs the enable high on the edge it watches
  // a low enable must leave every register alone, or a stalled core loses requests
  a_ce_freezes_state: assert property (@(posedge CLK_I) disable iff (RESET_I)
    !CE_I |=> ($stable(pending) && $stable(interrupt_mask_reg) && $stable(GRANT_O)))
    else $error("state changed while clock enable low");
  a_ack_clears_pending: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && CYCLE_ACK_I && GRANT_O.valid && !event_in[GRANT_O.line]) |=> !pending[$past(GRANT_O.line)])
    else $error("granted request still pending");
  a_ack_drops_req: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && CYCLE_ACK_I) |=> !IRQ_REQ_O)
    else $error("request held after interrupt cycle");
  a_active_raises_req: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && any_active && !CYCLE_ACK_I) |=> IRQ_REQ_O)
    else $error("enabled pending request not raised");
  a_grant_follows_winner: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && any_active && !CYCLE_ACK_I) |=> GRANT_O.line == $past(winner))
    else $error("granted line is not the encoder choice");
  a_disable_clears_master: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && DISABLE_INSN_I && !MASK_WR_I) |=> !interrupt_mask_reg[VIC_MASTER_BIT])
    else $error("disable instruction left master enable set");
  // mask write wins over every instruction pulse in the same cycle
  a_mask_write_lands: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && MASK_WR_I) |=> interrupt_mask_reg == $past(WDATA_I))
    else $error("mask write lost");
  a_prio_write_lands: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && PRIO_WR_I) |=> interrupt_priority_reg == $past(WDATA_I))
    else $error("priority write lost");
  a_fall_sets_line1: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && pin_last[3] && !pin_sync[3]) |=> pending[1])
    else $error("falling edge on pin bit 3 missed");
  a_fall_sets_line2: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && pin_last[1] && !pin_sync[1]) |=> pending[2])
    else $error("falling edge on pin bit 1 missed");
  a_fall_sets_line3: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && pin_last[0] && !pin_sync[0]) |=> pending[3])
    else $error("falling edge on pin bit 0 missed");
  // shared lines: either source alone must set the bit
  a_rx_line3: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && SERIAL_RX_I) |=> pending[3])
    else $error("receive event lost");
  a_timer0_line4: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && TIMER0_I) |=> pending[4])
    else $error("timer zero event lost");
endmodule : vic_ctrl

//--- verification/vic_core_model.sv
`timescale 1ns/10ps
module vic_core_model (
  input  wire logic       clk_i,
  input  wire logic       irq_i,
  input  wire logic [1:0] lag_i,
  output logic            ack_o
);
  logic [1:0] cnt = 2'h0;
  initial ack_o = 1'b0;
  // count 3 means served: no second cycle until the request falls
  always @(negedge clk_i) begin
    ack_o <= 1'b0;
    if (irq_i !== 1'b1) cnt <= 2'h0;
    else if (cnt == lag_i) begin
      ack_o <= 1'b1;
      cnt <= 2'h3;
    end else if (cnt != 2'h3) cnt <= cnt + 2'h1;
  end
endmodule : vic_core_model

//--- verification/vic_ctrl_tb.sv
`timescale 1ns/10ps
module vic_ctrl_tb;
  import vic_pkg::*;
  logic clk = 1'b0, rst = 1'b1, rx = 1'b0, tx = 1'b0, t0 = 1'b0, t1 = 1'b0, mwr = 1'b0, pwr = 1'b0;
  logic en = 1'b0, dis = 1'b0, ret = 1'b0, ce = 1'b1, ack, irq;
  logic [3:0] pin = 4'hf;
  logic [7:0] wd = 8'h00, mask, prio;
  logic [5:0] pend;
  logic [1:0] lag = 2'h0;
  vic_grant_s gr;
  int err_total = 0, tests_run = 0;
  int ln[8] = '{3, 2, 0, 1, 3, 4, 4, 5};
  always #4 clk = ~clk;
  vic_ctrl dut (.CLK_I(clk), .RESET_I(rst), .CE_I(ce), .PIN_I(pin), .SERIAL_RX_I(rx), .SERIAL_TX_I(tx),
    .TIMER0_I(t0), .TIMER1_I(t1), .MASK_WR_I(mwr), .PRIO_WR_I(pwr), .WDATA_I(wd), .ENABLE_INSN_I(en),
    .DISABLE_INSN_I(dis), .RETURN_INSN_I(ret), .CYCLE_ACK_I(ack), .IRQ_REQ_O(irq), .GRANT_O(gr),
    .MASK_O(mask), .PRIO_O(prio), .PENDING_O(pend));
  vic_core_model core (.clk_i(clk), .irq_i(irq), .lag_i(lag), .ack_o(ack));
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  task automatic setup(input logic [7:0] m, input logic [7:0] p);
    @(negedge clk) dis = 1'b1;
    @(negedge clk) {dis, mwr, wd} = {2'b01, m};
    @(negedge clk) {mwr, pwr, wd} = {2'b01, p};
    @(negedge clk) pwr = 1'b0;
    chk(mask === m && prio === p && irq === 1'b0, "mask or priority write");
  endtask : setup
  task automatic ev(input int k);
    @(negedge clk);
    case (k)
      0, 1, 2, 3: pin[k] = 1'b0;
      4: rx = 1'b1;
      5: tx = 1'b1;
      6: t0 = 1'b1;
      default: t1 = 1'b1;
    endcase
    @(negedge clk) {rx, tx, t0, t1} = 4'h0;
    repeat (4) @(negedge clk);
    // rising pin edge must not add a request
    pin = 4'hf;
    repeat (4) @(negedge clk);
  endtask : ev
  task automatic insn(input logic r);
    @(negedge clk) {en, ret} = {~r, r};
    @(negedge clk) {en, ret} = 2'b00;
  endtask : insn
  task automatic wirq(input logic v);
    int n = 0;
    while (irq !== v && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk(irq === v, "request level");
  endtask : wirq
  task automatic t_vec;
    for (int k = 0; k < 8; k++) begin
      lag = 2'(k % 3);
      setup(8'h00, 8'h00);
      ev(k);
      chk(pend === 6'h01 << ln[k], "pending while masked");
      setup(8'h01 << ln[k], 8'h00);
      insn(1'b0);
      wirq(1'b1);
      chk(gr.line === 3'(ln[k]) && gr.vec_lo === 8'(2 * ln[k]) && gr.vec_hi === 8'(2 * ln[k] + 1), "vector");
      wirq(1'b0);
      chk(pend === 6'h00 && mask[7] === 1'b0, "grant clears");
      insn(1'b1);
      chk(mask[7] === 1'b1, "return re-enables");
    end
    $display("test vec done");
  endtask : t_vec
  task automatic t_prio(input logic [7:0] p, input logic [2:0] a, input logic [2:0] b);
    setup(8'h00, p);
    ev(2);
    ev(7);
    setup(8'h21, p);
    insn(1'b0);
    wirq(1'b1);
    chk(gr.line === a, "first winner");
    wirq(1'b0);
    insn(1'b1);
    wirq(1'b1);
    chk(gr.line === b, "second winner");
    wirq(1'b0);
    chk(pend === 6'h00, "both served");
    $display("test prio done");
  endtask : t_prio
  // an event while the enable is low must be ignored; mwr stays low, so no mask write is made
  task automatic t_ce;
    setup(8'h00, 8'h00);
    @(negedge clk) {ce, t1, mwr, wd} = {3'b010, 8'hff};
    @(negedge clk) {ce, t1, mwr} = 3'b100;
    chk(pend === 6'h00 && mask === 8'h00, "state moved while clock enable low");
    $display("test ce done");
  endtask : t_ce
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    chk(mask === 8'h00 && pend === 6'h00 && irq === 1'b0, "reset values");
    t_vec;
    t_ce;
    t_prio(8'h00, 3'h0, 3'h5);
    t_prio(8'h05, 3'h5, 3'h0);
    tally_and_finish;
  end
  // whole run needs well under 1500 cycles
  initial begin
    #50000;
    err_total++;
    tally_and_finish;
  end
endmodule : vic_ctrl_tb
